/* File: rtl/scr_blink_gen.sv */
// shared blink prescaler: one phase counter for all leds
// assumes a synchronous active-low reset
`default_nettype none
module scr_blink_gen import scr_pkg::*; #(
	parameter int HALF_CYC = HALF_8HZ_CYC
) (
	input  wire logic               clk,
	input  wire logic               rst_n,
	output var  logic [PHASE_W-1:0] phase
);
	logic [TICK_W-1:0]  tick_q, tick_d;
	logic [PHASE_W-1:0] phase_q, phase_d;
	always_comb begin
		tick_d  = tick_q + 1'b1;
		phase_d = phase_q;
		if (tick_q == TICK_W'(HALF_CYC - 1)) begin
			tick_d  = '0;
			phase_d = phase_q + 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tick_q  <= '0;
			phase_q <= '0;
		end else begin
			tick_q  <= tick_d;
			phase_q <= phase_d;
		end
	end
	assign phase = phase_q;
endmodule // scr_blink_gen
`default_nettype wire

/* File: rtl/scr_pkg.sv */
// constants for the system configuration register block
// assumes one 100 MHz clock and an 8-bit register port
`default_nettype none
package scr_pkg;
	localparam logic [15:0] ADDR_CFG_LOW  = 16'hFF01;
	localparam logic [15:0] ADDR_CFG_HIGH = 16'hFF03;
	localparam logic [15:0] ADDR_BLINK    = 16'hFF04;
	localparam logic [15:0] ADDR_SYSCTL   = 16'hFF05;
	localparam logic [7:0]  BLINK_RST     = 8'h00;
	localparam logic [7:0]  SYSCTL_RST    = 8'h00;
	localparam logic [7:0]  BLINK_WMASK   = 8'h33;
	localparam logic [7:0]  SYSCTL_WMASK  = 8'h83;
	localparam logic [7:0]  CFG_HIGH_MASK = 8'h7F;
	localparam int FAST_LO = 4;
	localparam int SLOW_LO = 0;
	localparam int BIT_WDOG = 7;
	localparam int BIT_LOWV = 2;
	localparam int BIT_UART = 1;
	localparam int BIT_IRQ  = 0;
	localparam int BIT_DLEN = 5;
	localparam int BIT_SPEED = 4;
	localparam int BIT_PORT = 3;
	localparam logic [15:0] BRANCH_LAST = 16'h0002;
	localparam logic [15:0] DEST_11 = 16'h8000;
	localparam logic [15:0] DEST_10 = 16'h4000;
	localparam logic [15:0] DEST_01 = 16'h0033;
	localparam int CLK_HZ = 100000000;
	// fastest half period is 8 Hz: 1/16 s
	localparam int HALF_8HZ_CYC = CLK_HZ / 16;
	localparam int TICK_W = 23;
	// six phase bits: slowest half period is 32 fast halves (2 s)
	localparam int PHASE_W = 6;
endpackage : scr_pkg
`default_nettype wire

/* File: rtl/scr_regs.sv */
// system configuration registers, straps, blink rates, remaps
// assumes straps stable while rst_n is low; bus per plain port
//
// Local design decision: strobed register access.
`default_nettype none
module scr_regs import scr_pkg::*; #(
	parameter int HALF_CYC = HALF_8HZ_CYC
) (
	// clock and resets
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        softReset,
	// register port
	input  wire logic [15:0] regAddr,
	input  wire logic [7:0]  regWdata,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	output var  logic [7:0]  regRdata,
	// straps and status
	input  wire logic [7:0]  strapLow,
	input  wire logic [7:0]  strapHigh,
	input  wire logic        lowVoltDiff,
	input  wire logic        watchdogReset,
	// fetch substitution
	input  wire logic [15:0] fetchAddr,
	output var  logic        branchSubst,
	output var  logic [15:0] branchTarget,
	// download setup
	output var  logic        romDownloadStart,
	output var  logic        downloadFast,
	output var  logic        downloadPortSelect,
	output var  logic [2:0]  romChipAddress,
	// leds: 2-bit mode each, 00 off 01 on 10 fast 11 slow
	input  wire logic [15:0] ledMode,
	output var  logic [7:0]  ledOut,
	// pin remap
	output var  logic        resetPinDrive,
	output var  logic        uartPinRemap,
	output var  logic        extIrqPinRemap
);
	logic [7:0] cfgLow_q, cfgLow_d, cfgHigh_q, cfgHigh_d;
	logic [7:0] blink_q, blink_d, sys_q, sys_d, rdata_q, rdata_d;
	logic       seen_q, seen_d, start_q, start_d;
	logic       subst_q, subst_d, rstPin_q, rstPin_d;
	logic [15:0] target_q, target_d;
	logic [7:0] led_q, led_d;
	logic [PHASE_W-1:0] phase;
	logic fastWave, slowWave;
	logic [1:0] bsel;

	scr_blink_gen #(.HALF_CYC(HALF_CYC)) u_blink (
		.clk   (clk),
		.rst_n (rst_n),
		.phase (phase)
	);

	// phase bit k toggles every 2^k fast half periods
	always_comb begin
		fastWave = phase[blink_q[FAST_LO +: 2]];
		slowWave = phase[3'(blink_q[SLOW_LO +: 2]) + 3'd2];
	end

	assign bsel = cfgLow_q[1:0];

	always_comb begin
		// straps re-captured every reset cycle, frozen at release
		cfgLow_d  = cfgLow_q;
		cfgHigh_d = cfgHigh_q;
		blink_d   = blink_q;
		sys_d     = sys_q;
		seen_d    = 1'b1;
		start_d   = !seen_q && cfgLow_q[BIT_DLEN];
		rdata_d   = 8'h00;
		if (softReset) begin
			blink_d = BLINK_RST;
			sys_d   = sys_q & (8'h01 << BIT_WDOG);
			seen_d  = 1'b0;
			start_d = 1'b0;
		end else if (regWrite) begin
			// reserved and read-only bits never store; is software's side
			unique case (regAddr)
				ADDR_BLINK:  blink_d = regWdata & BLINK_WMASK;
				ADDR_SYSCTL: sys_d   = regWdata & SYSCTL_WMASK;
				default: ;
			endcase
		end
		if (regRead) begin
			unique case (regAddr)
				ADDR_CFG_LOW:  rdata_d = cfgLow_q;
				ADDR_CFG_HIGH: rdata_d = cfgHigh_q;
				ADDR_BLINK:    rdata_d = blink_q;
				ADDR_SYSCTL: begin
					rdata_d = sys_q;
					rdata_d[BIT_LOWV] = lowVoltDiff;
				end
				default:       rdata_d = 8'h00;
			endcase
		end
		subst_d  = (fetchAddr <= BRANCH_LAST) && (bsel != 2'b00);
		unique case (bsel)
			2'b11:   target_d = DEST_11;
			2'b10:   target_d = DEST_10;
			2'b01:   target_d = DEST_01;
			default: target_d = 16'h0000;
		endcase
		rstPin_d = watchdogReset && sys_q[BIT_WDOG];
		for (int i = 0; i < 8; i++) begin
			unique case (ledMode[2*i +: 2])
				2'b00:   led_d[i] = 1'b0;
				2'b01:   led_d[i] = 1'b1;
				2'b10:   led_d[i] = fastWave;
				default: led_d[i] = slowWave;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			// hard reset: straps are sampled clocked, never as async load
			cfgLow_q  <= strapLow;
			cfgHigh_q <= strapHigh & CFG_HIGH_MASK;
			blink_q   <= BLINK_RST;
			sys_q     <= SYSCTL_RST;
			seen_q    <= 1'b0;
			start_q   <= 1'b0;
			rdata_q   <= 8'h00;
			subst_q   <= 1'b0;
			target_q  <= 16'h0000;
			rstPin_q  <= 1'b0;
			led_q     <= 8'h00;
		end else begin
			cfgLow_q  <= cfgLow_d;
			cfgHigh_q <= cfgHigh_d;
			blink_q   <= blink_d;
			sys_q     <= sys_d;
			seen_q    <= seen_d;
			start_q   <= start_d;
			rdata_q   <= rdata_d;
			subst_q   <= subst_d;
			target_q  <= target_d;
			rstPin_q  <= rstPin_d;
			led_q     <= led_d;
		end
	end

	assign regRdata           = rdata_q;
	assign branchSubst        = subst_q;
	assign branchTarget       = target_q;
	assign romDownloadStart   = start_q;
	assign downloadFast       = cfgHigh_q[BIT_SPEED];
	assign downloadPortSelect = cfgHigh_q[BIT_PORT];
	assign romChipAddress     = cfgHigh_q[2:0];
	assign ledOut             = led_q;
	assign resetPinDrive      = rstPin_q;
	assign uartPinRemap       = sys_q[BIT_UART];
	assign extIrqPinRemap     = sys_q[BIT_IRQ];

	chk_start_pulse: assert property (@(posedge clk) disable iff (!rst_n)
		romDownloadStart |=> !romDownloadStart) else $error("download start not one cycle");
	chk_start_cause: assert property (@(posedge clk) disable iff (!rst_n)
		romDownloadStart |-> cfgLow_q[BIT_DLEN]) else $error("download start without enable");
	chk_branch_window: assert property (@(posedge clk) disable iff (!rst_n)
		branchSubst |-> ($past(fetchAddr) <= 16'h0002)) else $error("substitution outside window");
	chk_branch_dest: assert property (@(posedge clk) disable iff (!rst_n)
		(branchSubst && cfgLow_q[1:0] == 2'b01) |-> branchTarget == 16'h0033)
		else $error("wrong branch target");
	chk_cfg_stable: assert property (@(posedge clk) disable iff (!rst_n)
		$stable(cfgHigh_q) && $stable(cfgLow_q)) else $error("config changed without reset");
	chk_wdog_keep: assert property (@(posedge clk) disable iff (!rst_n)
		(softReset && sys_q[7]) |=> sys_q[7]) else $error("watchdog enable lost");
	chk_wdog_pin: assert property (@(posedge clk) disable iff (!rst_n)
		(watchdogReset && sys_q[7] && !softReset) |=> resetPinDrive) else $error("reset pin idle");
	chk_lowv_read: assert property (@(posedge clk) disable iff (!rst_n)
		(regRead && regAddr == ADDR_SYSCTL) |=> regRdata[BIT_LOWV] == $past(lowVoltDiff))
		else $error("low voltage flag misread");
	chk_blink_reserved: assert property (@(posedge clk) disable iff (!rst_n)
		(blink_q & 8'hCC) == 8'h00) else $error("reserved blink bits set");
	chk_led_on: assert property (@(posedge clk) disable iff (!rst_n)
		(ledMode[1:0] == 2'b01) |=> ledOut[0]) else $error("steady led not on");

	cov_download: cover property (@(posedge clk) romDownloadStart);
	cov_subst: cover property (@(posedge clk) branchSubst);
	cov_fast_toggle: cover property (@(posedge clk) $rose(fastWave));
	cov_soft: cover property (@(posedge clk) softReset && sys_q[7]);
endmodule // scr_regs
`default_nettype wire

/* File: tb/tb_scr_regs.sv */
// self-checking bench for the configuration register block
// drives every port itself; prescaler shortened to 4 cycles per half
`default_nettype none
module tb_scr_regs import scr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int H = 4;
	logic        clk, rst_n, softReset, regWrite, regRead, lowVoltDiff, watchdogReset;
	logic [15:0] regAddr, fetchAddr, ledMode, branchTarget;
	logic [7:0]  regWdata, regRdata, strapLow, strapHigh, ledOut;
	logic        branchSubst, romDownloadStart, downloadFast, downloadPortSelect;
	logic        resetPinDrive, uartPinRemap, extIrqPinRemap;
	logic [2:0]  romChipAddress;
	int          errors, check_count;
	logic [15:0] dlSetup;
	// write address, write data, value read back
	logic [31:0] rows [7] = '{32'hFF04_FF33, 32'hFF04_1212, 32'hFF01_00FE, 32'hFF03_001D,
		32'hFF00_AA00, 32'hFF06_5500, 32'hFF05_FF83};

	scr_regs #(.HALF_CYC(H)) DUT (.clk, .rst_n, .softReset, .regAddr, .regWdata, .regWrite,
		.regRead, .regRdata, .strapLow, .strapHigh, .lowVoltDiff, .watchdogReset, .fetchAddr,
		.branchSubst, .branchTarget, .romDownloadStart, .downloadFast, .downloadPortSelect,
		.romChipAddress, .ledMode, .ledOut, .resetPinDrive, .uartPinRemap, .extIrqPinRemap);

	assign dlSetup = 16'({downloadFast, downloadPortSelect, romChipAddress});

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic finish_test();
		if (errors == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one gap cycle after every strobe keeps each strobe a single assignment per step
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1;
		cmp("read data", {8'h00, e}, {8'h00, regRdata});
	endtask

	task automatic hardReset(input logic [7:0] sl, input logic [7:0] sh, input int p);
		int c;
		c = 0;
		@(posedge clk);
		rst_n <= 1'b0;
		strapLow <= sl;
		strapHigh <= sh;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) begin
			@(posedge clk);
			#1;
			c += int'(romDownloadStart === 1'b1);
		end
		cmp("download start", 16'(p), 16'(c));
	endtask

	// waits for a rising led edge, then counts the high time; phase is unknown
	task automatic meas(input int i, input int h);
		int n, k;
		n = 0;
		k = 0;
		while (ledOut[i] !== 1'b0 && k < 1200) begin
			@(posedge clk);
			#1;
			k++;
		end
		while (ledOut[i] !== 1'b1 && k < 1200) begin
			@(posedge clk);
			#1;
			k++;
		end
		while (ledOut[i] === 1'b1 && k < 1200) begin
			@(posedge clk);
			#1;
			n++;
			k++;
		end
		if (k >= 1200) begin
			errors++;
			finish_test();
		end else begin
			cmp("blink high time", 16'(h), 16'(n));
		end
	endtask

	initial begin
		{rst_n, softReset, regWrite, regRead, lowVoltDiff, watchdogReset} = 6'h00;
		{regAddr, fetchAddr, ledMode, regWdata, strapLow, strapHigh} = '0;
		errors = 0;
		check_count = 0;
		hardReset(8'hFE, 8'h9D, 1);
		cmp("download setup", 16'h001D, dlSetup);
		rd(ADDR_SYSCTL, 8'h00);
		foreach (rows[i]) begin
			wr(rows[i][31:16], rows[i][15:8]);
			rd(rows[i][31:16], rows[i][7:0]);
		end
		cmp("pin remaps", 16'h0003, 16'({uartPinRemap, extIrqPinRemap}));
		lowVoltDiff <= 1'b1;
		watchdogReset <= 1'b1;
		fetchAddr <= 16'h0002;
		rd(ADDR_SYSCTL, 8'h87);
		cmp("reset pin", 16'h0001, 16'(resetPinDrive));
		cmp("branch taken", 16'h0001, 16'(branchSubst));
		cmp("branch target", 16'h4000, branchTarget);
		fetchAddr <= 16'h0003;
		ledMode <= 16'h00E1;
		repeat (3) @(posedge clk);
		#1;
		cmp("no branch", 16'h0000, 16'(branchSubst));
		// every fast and every slow select, high time in clock cycles
		for (int s = 0; s < 4; s++) begin
			wr(ADDR_BLINK, {2'b00, s[1:0], 2'b00, s[1:0]});
			meas(2, H << s);
			meas(3, H << (s + 2));
		end
		cmp("steady leds", 16'h0001, 16'(ledOut[1:0]));
		@(posedge clk);
		softReset <= 1'b1;
		lowVoltDiff <= 1'b0;
		@(posedge clk);
		softReset <= 1'b0;
		@(posedge clk);
		#1;
		cmp("download restart", 16'h0001, 16'(romDownloadStart));
		cmp("remaps cleared", 16'h0000, 16'({uartPinRemap, extIrqPinRemap}));
		rd(ADDR_SYSCTL, 8'h80);
		rd(ADDR_BLINK, 8'h00);
		rd(ADDR_CFG_HIGH, 8'h1D);
		hardReset(8'h01, 8'h62, 0);
		rd(ADDR_CFG_HIGH, 8'h62);
		rd(ADDR_SYSCTL, 8'h00);
		fetchAddr <= 16'h0000;
		repeat (3) @(posedge clk);
		#1;
		cmp("branch low", 16'h0001, 16'(branchSubst));
		cmp("target low", 16'h0033, branchTarget);
		cmp("download low", 16'h0002, dlSetup);
		cmp("reset pin off", 16'h0000, 16'(resetPinDrive));
		finish_test();
	end
endmodule // tb_scr_regs
`default_nettype wire
